//--- core/ptf_timebase.sv
`timescale 1ns/100ps
`default_nettype none
module ptf_timebase
  import ptf_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic resetn_i,
  ptf_tick_if.src   tb
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } ptf_tb_s;

  ptf_tb_s r;
  ptf_tb_s next_r;

  // one tick every div cycles, div of zero acts as one
  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (r.cnt + 16'h0001 >= tb.div) begin
      next_r.cnt  = 16'h0000;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tb.tick = r.tick;

endmodule : ptf_timebase
`default_nettype wire

//--- core/ptf_top.sv
`timescale 1ns/100ps
`default_nettype none
module ptf_top
  import ptf_pkg::*;
#(
  parameter int CW   = 16,
  parameter int NBLK = 8
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  // register port
  input  wire logic [3:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  // live values of other blocks
  input  wire logic [NBLK*CW-1:0] ext_val_i,
  // function inputs
  input  wire logic             wp_trg_i,
  input  wire logic             et_trg_i,
  input  wire logic             et_kill_i,
  input  wire logic             ag_en_i,
  input  wire logic             ag_inv_i,
  input  wire logic             pwr_restore_i,
  // function outputs
  output logic                  wp_q_o,
  output logic                  et_q_o,
  output logic                  ag_q_o
);

  // elaboration check of parameters
  if (CW < 1 || CW > 16 || NBLK < 1 || NBLK > 15) begin : g_bad_param
    $error("ptf_top: CW must be 1..16 and NBLK 1..15");
  end

  typedef struct packed {
    logic [IN_W-1:0]  s1;
    logic [IN_W-1:0]  s2;
    logic [IN_W-1:0]  s3;
    logic [15:0]      tb_div;
    logic [CW-1:0]    wp_dur;
    logic [CW-1:0]    et_low;
    logic [CW-1:0]    et_high;
    logic [3:0]       et_cnt;
    logic [CW-1:0]    ag_high;
    logic [CW-1:0]    ag_low;
    logic [SRC_W-1:0] src;
    logic [2:0]       ret;
    logic             wp_q;
    logic [CW-1:0]    wp_ta;
    ptf_et_e          et_st;
    logic [3:0]       et_n;
    logic [CW-1:0]    et_ta;
    logic             ag_hi;
    logic             ag_q;
    logic [CW-1:0]    ag_ta;
    logic [31:0]      rdata;
  } ptf_top_s;

  ptf_top_s r;
  ptf_top_s next_r;

  ptf_tick_if tbus ();

  ptf_timebase u_timebase (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .tb       (tbus.src)
  );

  assign tbus.div = r.tb_div;

  // constant or live value of another block
  function automatic logic [CW-1:0] pick(
    input logic [3:0]         num,
    input logic [CW-1:0]      konst,
    input logic [NBLK*CW-1:0] ext
  );
    logic [CW-1:0] v;
    v = konst;
    for (int i = 0; i < NBLK; i++) begin
      if (num == 4'(i + 1)) begin
        v = ext[i*CW +: CW];
      end
    end
    return v;
  endfunction : pick

  // zero-extend a time to a bus word
  function automatic logic [31:0] word(input logic [CW-1:0] v);
    logic [31:0] w;
    w = '0;
    w[CW-1:0] = v;
    return w;
  endfunction : word

  logic [CW-1:0] wp_dur_eff;
  logic [CW-1:0] et_low_eff;
  logic [CW-1:0] et_high_eff;
  logic [CW-1:0] ag_high_eff;
  logic [CW-1:0] ag_low_eff;

  // effective times
  always_comb begin
    wp_dur_eff  = pick(r.src[SRC_WP_DUR +: 4], r.wp_dur, ext_val_i);
    et_low_eff  = pick(r.src[SRC_ET_LOW +: 4], r.et_low, ext_val_i);
    et_high_eff = pick(r.src[SRC_ET_HIGH +: 4], r.et_high, ext_val_i);
    ag_high_eff = pick(r.src[SRC_AG_HIGH +: 4], r.ag_high, ext_val_i);
    ag_low_eff  = pick(r.src[SRC_AG_LOW +: 4], r.ag_low, ext_val_i);
  end

  logic wp_rise;
  logic wp_fall;
  logic et_rise;
  logic et_kill;
  logic ag_en;
  logic ag_inv;
  logic pwr_rise;
  logic tick;

  // edges from the second and third stages, levels from the second stage only
  always_comb begin
    wp_rise  = r.s2[IN_WP_TRG] & ~r.s3[IN_WP_TRG];
    wp_fall  = ~r.s2[IN_WP_TRG] & r.s3[IN_WP_TRG];
    et_rise  = r.s2[IN_ET_TRG] & ~r.s3[IN_ET_TRG];
    et_kill  = r.s2[IN_ET_KILL];
    ag_en    = r.s2[IN_AG_EN];
    ag_inv   = r.s2[IN_AG_INV];
    pwr_rise = r.s2[IN_PWR] & ~r.s3[IN_PWR];
    tick     = tbus.tick;
  end

  // next state of every function and of the register file
  always_comb begin
    next_r    = r;
    // input synchronisers
    next_r.s1 = {pwr_restore_i, ag_inv_i, ag_en_i, et_kill_i, et_trg_i, wp_trg_i};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;

    // single pulse
    if (wp_rise) begin
      next_r.wp_q  = 1'b1;
      next_r.wp_ta = '0;
    end else if (r.wp_q && wp_fall) begin
      next_r.wp_q = 1'b0;
    end else if (r.wp_q) begin
      if (r.wp_ta >= wp_dur_eff) begin
        next_r.wp_q = 1'b0;
      end else if (tick) begin
        next_r.wp_ta = r.wp_ta + 1'b1;
      end
    end

    // delayed pulse train
    if (et_kill) begin
      next_r.et_st = ET_IDLE;
      next_r.et_ta = '0;
      next_r.et_n  = '0;
    end else if (et_rise) begin
      next_r.et_st = ET_LOW;
      next_r.et_ta = '0;
      next_r.et_n  = '0;
    end else begin
      case (r.et_st)
        ET_IDLE: begin
          next_r.et_ta = r.et_ta;
        end
        ET_LOW: begin
          if (r.et_ta >= et_low_eff) begin
            next_r.et_st = ET_HIGH;
            next_r.et_ta = '0;
          end else if (tick) begin
            next_r.et_ta = r.et_ta + 1'b1;
          end
        end
        ET_HIGH: begin
          if (r.et_ta >= et_high_eff) begin
            next_r.et_ta = '0;
            next_r.et_n  = r.et_n + 4'h1;
            if (r.et_n + 4'h1 >= r.et_cnt) begin
              next_r.et_st = ET_IDLE;
            end else begin
              next_r.et_st = ET_LOW;
            end
          end else if (tick) begin
            next_r.et_ta = r.et_ta + 1'b1;
          end
        end
        default: begin
          next_r.et_st = ET_IDLE;
          next_r.et_ta = '0;
        end
      endcase
    end

    // free running generator
    if (!ag_en) begin
      next_r.ag_hi = 1'b1;
      next_r.ag_ta = '0;
    end else if (r.ag_hi) begin
      if (r.ag_ta >= ag_high_eff) begin
        next_r.ag_hi = 1'b0;
        next_r.ag_ta = '0;
      end else if (tick) begin
        next_r.ag_ta = r.ag_ta + 1'b1;
      end
    end else begin
      if (r.ag_ta >= ag_low_eff) begin
        next_r.ag_hi = 1'b1;
        next_r.ag_ta = '0;
      end else if (tick) begin
        next_r.ag_ta = r.ag_ta + 1'b1;
      end
    end
    next_r.ag_q = ag_en & (next_r.ag_hi ^ ag_inv);

    // power return: non-retained blocks go to defaults
    if (pwr_rise) begin
      if (!r.ret[RET_WP]) begin
        next_r.wp_q  = 1'b0;
        next_r.wp_ta = '0;
      end
      if (!r.ret[RET_ET]) begin
        next_r.et_st = ET_IDLE;
        next_r.et_ta = '0;
        next_r.et_n  = '0;
      end
      if (!r.ret[RET_AG]) begin
        next_r.ag_hi = 1'b1;
        next_r.ag_ta = '0;
        next_r.ag_q  = 1'b0;
      end
    end

    // register writes
    if (wr_i) begin
      case (addr_i)
        ADDR_TB_DIV:  next_r.tb_div  = wdata_i[15:0];
        ADDR_WP_DUR:  next_r.wp_dur  = wdata_i[CW-1:0];
        ADDR_ET_LOW:  next_r.et_low  = wdata_i[CW-1:0];
        ADDR_ET_HIGH: next_r.et_high = wdata_i[CW-1:0];
        ADDR_ET_CNT: begin
          if (wdata_i[31:0] < 32'(ET_CNT_MIN)) begin
            next_r.et_cnt = ET_CNT_MIN;
          end else if (wdata_i[31:0] > 32'(ET_CNT_MAX)) begin
            next_r.et_cnt = ET_CNT_MAX;
          end else begin
            next_r.et_cnt = wdata_i[3:0];
          end
        end
        ADDR_AG_HIGH: next_r.ag_high = wdata_i[CW-1:0];
        ADDR_AG_LOW:  next_r.ag_low  = wdata_i[CW-1:0];
        ADDR_SRC:     next_r.src     = wdata_i[SRC_W-1:0];
        ADDR_RETAIN:  next_r.ret     = wdata_i[2:0];
        default: begin
          next_r.ret = next_r.ret;
        end
      endcase
    end

    // register reads, data in the following cycle
    next_r.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        ADDR_TB_DIV:  next_r.rdata = {16'h0000, r.tb_div};
        ADDR_WP_DUR:  next_r.rdata = word(r.wp_dur);
        ADDR_ET_LOW:  next_r.rdata = word(r.et_low);
        ADDR_ET_HIGH: next_r.rdata = word(r.et_high);
        ADDR_ET_CNT:  next_r.rdata = {28'h0000000, r.et_cnt};
        ADDR_AG_HIGH: next_r.rdata = word(r.ag_high);
        ADDR_AG_LOW:  next_r.rdata = word(r.ag_low);
        ADDR_SRC:     next_r.rdata = {12'h000, r.src};
        ADDR_RETAIN:  next_r.rdata = {29'h00000000, r.ret};
        ADDR_STATUS: begin
          next_r.rdata[ST_WP_Q]       = r.wp_q;
          next_r.rdata[ST_ET_Q]       = (r.et_st == ET_HIGH);
          next_r.rdata[ST_AG_Q]       = r.ag_q;
          next_r.rdata[ST_ET_ST +: 3] = r.et_st;
          next_r.rdata[ST_ET_N +: 4]  = r.et_n;
        end
        ADDR_WP_TA:   next_r.rdata = word(r.wp_ta);
        ADDR_ET_TA:   next_r.rdata = word(r.et_ta);
        ADDR_AG_TA:   next_r.rdata = word(r.ag_ta);
        default:      next_r.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r         <= '0;
      r.tb_div  <= RST_TB_DIV;
      r.wp_dur  <= RST_TIME[CW-1:0];
      r.et_low  <= RST_TIME[CW-1:0];
      r.et_high <= RST_TIME[CW-1:0];
      r.et_cnt  <= RST_ET_CNT;
      r.ag_high <= RST_TIME[CW-1:0];
      r.ag_low  <= RST_TIME[CW-1:0];
      r.et_st   <= ET_IDLE;
      r.ag_hi   <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops, except et_q_o, which is decoded from the et_st register
  assign rdata_o = r.rdata;
  assign wp_q_o  = r.wp_q;
  assign et_q_o  = (r.et_st == ET_HIGH);
  assign ag_q_o  = r.ag_q;

endmodule : ptf_top
`default_nettype wire

//--- shared/ptf_pkg.sv
// Contract
// - single pulse: trigger rising edge raises output at once and starts elapsed time
// - single pulse: output drops when elapsed time equals the pulse duration
// - single pulse: trigger falling edge before expiry ends the pulse at once
// - every function has its own retention switch, off or on
// - on power return, retained blocks keep output and time, others reset
// - pulse duration is a constant or another block's live value, by number
// - pulse train: active kill input clears elapsed time and drops output
// - pulse train emits one to nine low/high cycles per trigger
// - pulse train: rising edge starts low time, then high time with output set
// - pulse train: rising edge before low plus high elapsed restarts the sequence
// - high and low times are constants or another block's live value, by number
// - free generator runs while enable is active and stops when it drops
// - free generator output alternates high for high time, low for low time
// - with invert active and generator enabled, the output is inverted
package ptf_pkg;

  // register word addresses
  localparam logic [3:0] ADDR_TB_DIV  = 4'h0;
  localparam logic [3:0] ADDR_WP_DUR  = 4'h1;
  localparam logic [3:0] ADDR_ET_LOW  = 4'h2;
  localparam logic [3:0] ADDR_ET_HIGH = 4'h3;
  localparam logic [3:0] ADDR_ET_CNT  = 4'h4;
  localparam logic [3:0] ADDR_AG_HIGH = 4'h5;
  localparam logic [3:0] ADDR_AG_LOW  = 4'h6;
  localparam logic [3:0] ADDR_SRC     = 4'h7;
  localparam logic [3:0] ADDR_RETAIN  = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'h9;
  localparam logic [3:0] ADDR_WP_TA   = 4'ha;
  localparam logic [3:0] ADDR_ET_TA   = 4'hb;
  localparam logic [3:0] ADDR_AG_TA   = 4'hc;

  // source select fields, four bits each, 0 selects the constant
  localparam int SRC_WP_DUR  = 0;
  localparam int SRC_ET_LOW  = 4;
  localparam int SRC_ET_HIGH = 8;
  localparam int SRC_AG_HIGH = 12;
  localparam int SRC_AG_LOW  = 16;
  localparam int SRC_W       = 20;

  // retention bits
  localparam int RET_WP = 0;
  localparam int RET_ET = 1;
  localparam int RET_AG = 2;

  // synchronised input bits
  localparam int IN_WP_TRG  = 0;
  localparam int IN_ET_TRG  = 1;
  localparam int IN_ET_KILL = 2;
  localparam int IN_AG_EN   = 3;
  localparam int IN_AG_INV  = 4;
  localparam int IN_PWR     = 5;
  localparam int IN_W       = 6;

  // status bits
  localparam int ST_WP_Q  = 0;
  localparam int ST_ET_Q  = 1;
  localparam int ST_AG_Q  = 2;
  localparam int ST_ET_ST = 4;
  localparam int ST_ET_N  = 8;

  // cycle count limits
  localparam logic [3:0] ET_CNT_MIN = 4'h1;
  localparam logic [3:0] ET_CNT_MAX = 4'h9;

  // reset values
  localparam logic [15:0] RST_TB_DIV = 16'h00c8;
  localparam logic [15:0] RST_TIME   = 16'h000a;
  localparam logic [3:0]  RST_ET_CNT = 4'h1;

  typedef enum logic [2:0] {
    ET_IDLE = 3'b001,
    ET_LOW  = 3'b010,
    ET_HIGH = 3'b100
  } ptf_et_e;

endpackage : ptf_pkg

//--- shared/ptf_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
// timebase divider setting out, tick pulse back
interface ptf_tick_if;
  logic [15:0] div;
  logic        tick;
  modport src (input div, output tick);
  modport snk (output div, input tick);
endinterface : ptf_tick_if
`default_nettype wire

//--- tb/ptf_partner.sv
`timescale 1ns/100ps
`default_nettype none
module ptf_partner #(
  parameter int CW   = 16,
  parameter int NBLK = 8
) (
  input  wire logic                 clk_i,
  input  wire logic                 ld_i,
  input  wire logic [3:0]           blk_i,
  input  wire logic [CW-1:0]        val_i,
  output var  logic [NBLK*CW-1:0]   ext_val_o
);
  // live value of block k sits in slot k-1, changes just after the edge
  initial ext_val_o = '0;
  always @(posedge clk_i) begin
    if (ld_i) begin
      ext_val_o[(int'(blk_i) - 1)*CW +: CW] <= val_i;
    end
  end
endmodule : ptf_partner
`default_nettype wire

//--- tb/ptf_props.sv
`timescale 1ns/100ps
`default_nettype none
module ptf_props (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic wp_trg_i,
  input wire logic et_trg_i,
  input wire logic et_kill_i,
  input wire logic ag_en_i,
  input wire logic ag_inv_i,
  input wire logic wp_q_o,
  input wire logic et_q_o,
  input wire logic ag_q_o
);
  // one clock domain, reset aborts every attempt
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // inputs held long enough to clear the synchroniser
  sequence s_kill_held; et_kill_i[*5]; endsequence
  sequence s_gen_off; !ag_en_i[*5]; endsequence
  sequence s_trg_quiet; !wp_trg_i[*8]; endsequence
  a_wp_set: assert property ($rose(wp_trg_i) |-> ##[2:5] wp_q_o)
    else $error("single pulse not raised after trigger");
  a_wp_cause: assert property ($rose(wp_q_o) |-> $past(wp_trg_i, 2))
    else $error("single pulse raised without trigger");
  a_wp_early_end: assert property ($fell(wp_trg_i) |-> ##[1:5] !wp_q_o)
    else $error("single pulse not ended by falling trigger");
  a_wp_quiet: assert property (s_trg_quiet |-> !wp_q_o)
    else $error("single pulse high with trigger low");
  a_et_kill: assert property (s_kill_held |-> !et_q_o)
    else $error("pulse train high while cleared");
  a_et_restart: assert property ($rose(et_trg_i) && !et_kill_i |-> ##[2:5] !et_q_o)
    else $error("pulse train not restarted in low phase");
  a_ag_start: assert property ($rose(ag_en_i) && !ag_inv_i |-> ##[2:5] ag_q_o)
    else $error("generator did not start high");
  a_ag_stop: assert property (s_gen_off |-> !ag_q_o)
    else $error("generator output high while disabled");
endmodule : ptf_props
`default_nettype wire
bind ptf_top ptf_props u_props (
  .clk_i(clk_i), .resetn_i(resetn_i), .wp_trg_i(wp_trg_i), .et_trg_i(et_trg_i), .et_kill_i(et_kill_i),
  .ag_en_i(ag_en_i), .ag_inv_i(ag_inv_i), .wp_q_o(wp_q_o), .et_q_o(et_q_o), .ag_q_o(ag_q_o)
);

//--- tb/ptf_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module ptf_top_test;
  import ptf_pkg::*;
  logic clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, ld = 1'b0;
  logic wp_trg_i = 1'b0, et_trg_i = 1'b0, et_kill_i = 1'b0, ag_en_i = 1'b0, ag_inv_i = 1'b0, pwr_i = 1'b0;
  logic [3:0] addr_i = 4'h0, blk = 4'h1;
  logic [15:0] val = 16'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  logic [127:0] ext_val;
  logic wp_q_o, et_q_o, ag_q_o;
  logic [2:0] q3;
  // outputs gathered for indexed watching
  assign q3 = {ag_q_o, et_q_o, wp_q_o};
  int num_errors = 0, checked = 0, cycles = 0, w;
  ptf_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ext_val_i(ext_val), .wp_trg_i(wp_trg_i), .et_trg_i(et_trg_i),
    .et_kill_i(et_kill_i), .ag_en_i(ag_en_i), .ag_inv_i(ag_inv_i), .pwr_restore_i(pwr_i),
    .wp_q_o(wp_q_o), .et_q_o(et_q_o), .ag_q_o(ag_q_o));
  ptf_partner u_blocks (.clk_i(clk_i), .ld_i(ld), .blk_i(blk), .val_i(val), .ext_val_o(ext_val));
  // 200 MHz clock and cycle ceiling
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // comparisons
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rng(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : rng
  // register port cycles
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task set_blk(input logic [3:0] k, input logic [15:0] v);
    @(posedge clk_i);
    ld <= 1'b1;
    blk <= k;
    val <= v;
    @(posedge clk_i);
    ld <= 1'b0;
  endtask : set_blk
  task wait_n(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_n
  // length of next run of level lvl on output i
  task width(input int i, input logic lvl, output int n);
    int t;
    t = 0;
    n = 0;
    while (q3[i] !== lvl && t < 200) begin
      wait_n(1);
      t++;
    end
    while (q3[i] === lvl && n < 200) begin
      wait_n(1);
      n++;
    end
  endtask : width
  // rising edges of the pulse train over a span
  task pulses(input int span, output int n);
    logic p;
    n = 0;
    p = et_q_o;
    repeat (span) begin
      wait_n(1);
      if (et_q_o === 1'b1 && p === 1'b0) n++;
      p = et_q_o;
    end
  endtask : pulses
  task t_regs;
    rd(ADDR_WP_DUR, d); chk(d, {16'h0, RST_TIME});
    rd(ADDR_RETAIN, d); chk(d, 32'h0);
    rd(4'hd, d); chk(d, 32'h0);
    wr(ADDR_ET_CNT, 32'h0); rd(ADDR_ET_CNT, d); chk(d, {28'h0, ET_CNT_MIN});
    wr(ADDR_ET_CNT, 32'hf); rd(ADDR_ET_CNT, d); chk(d, {28'h0, ET_CNT_MAX});
    wr(ADDR_TB_DIV, 32'h1);
  endtask : t_regs
  task t_wp;
    wr(ADDR_WP_DUR, 32'h6);
    @(posedge clk_i) wp_trg_i <= 1'b1;
    width(0, 1'b1, w); rng(w, 6, 8);
    @(posedge clk_i) wp_trg_i <= 1'b0;
    wr(ADDR_WP_DUR, 32'h28);
    @(posedge clk_i) wp_trg_i <= 1'b1;
    wait_n(8); chk(wp_q_o, 1'b1);
    @(posedge clk_i) wp_trg_i <= 1'b0;
    wait_n(6); chk(wp_q_o, 1'b0);
  endtask : t_wp
  task t_pwr(input logic keep);
    wr(ADDR_RETAIN, {31'h0, keep});
    @(posedge clk_i) wp_trg_i <= 1'b1;
    wait_n(10);
    @(posedge clk_i) pwr_i <= 1'b1;
    wait_n(3);
    @(posedge clk_i) pwr_i <= 1'b0;
    wait_n(6); chk(wp_q_o, keep);
    @(posedge clk_i) wp_trg_i <= 1'b0;
    wait_n(8);
  endtask : t_pwr
  task t_et;
    wr(ADDR_ET_LOW, 32'h3); wr(ADDR_ET_HIGH, 32'h2); wr(ADDR_ET_CNT, 32'h3);
    @(posedge clk_i) et_trg_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    et_trg_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    et_trg_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    et_trg_i <= 1'b0;
    pulses(80, w); chk(w, 3);
    @(posedge clk_i) et_trg_i <= 1'b1;
    width(1, 1'b1, w); rng(w, 2, 4);
    pulses(60, w); chk(w, 2);
    @(posedge clk_i) et_trg_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    et_trg_i <= 1'b1;
    width(1, 1'b0, w); rng(w, 3, 8);
    @(posedge clk_i) et_kill_i <= 1'b1;
    wait_n(6); chk(et_q_o, 1'b0);
    rd(ADDR_ET_TA, d); chk(d, 32'h0);
    rd(ADDR_STATUS, d); chk(d[6:4], 3'b001);
    @(posedge clk_i) et_kill_i <= 1'b0;
    et_trg_i <= 1'b0;
  endtask : t_et
  task t_ag;
    set_blk(4'h2, 16'h5);
    wr(ADDR_SRC, 32'h2000); wr(ADDR_AG_LOW, 32'h8);
    @(posedge clk_i) ag_en_i <= 1'b1;
    width(2, 1'b1, w); rng(w, 5, 7);
    width(2, 1'b0, w); rng(w, 8, 10);
    @(posedge clk_i) ag_inv_i <= 1'b1;
    width(2, 1'b0, w);
    width(2, 1'b1, w); rng(w, 8, 10);
    @(posedge clk_i) ag_en_i <= 1'b0;
    wait_n(6); chk(ag_q_o, 1'b0);
    @(posedge clk_i) ag_inv_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    ag_en_i <= 1'b1;
    wait_n(6); chk(ag_q_o, 1'b1);
  endtask : t_ag
  // verdict and end of run
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // reset for 16 cycles, then scenarios
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_wp();
    set_blk(4'h1, 16'h9);
    wr(ADDR_SRC, 32'h1);
    @(posedge clk_i) wp_trg_i <= 1'b1;
    width(0, 1'b1, w); rng(w, 9, 11);
    @(posedge clk_i) wp_trg_i <= 1'b0;
    set_blk(4'h1, 16'h3c);
    t_pwr(1'b1);
    t_pwr(1'b0);
    t_et();
    t_ag();
    finish_test();
  end
endmodule : ptf_top_test
`default_nettype wire
